// File: hdl/buck_voltage_select_pkg.sv
/*
  Constants for the third converter voltage-select and ramp-rate bank.
  Assumes a 50 MHz core clock and a byte-wide register port fed by the
  serial interface engine on the same clock.
*/
package buck_voltage_select_pkg;

  localparam logic [7:0] LOW_LEVEL_OFFSET  = 8'h13;
  localparam logic [7:0] HIGH_LEVEL_OFFSET = 8'h14;
  localparam logic [7:0] RAMP_RATE_OFFSET  = 8'h15;

  localparam int EXT_ADJUST_BIT = 7;
  localparam int CODE_MSB       = 5;
  localparam int RATE_MSB       = 2;

  // Variant defaults; the values below belong to one build option
  localparam logic [5:0] LOW_CODE_RESET  = 6'h0B;
  localparam logic [5:0] HIGH_CODE_RESET = 6'h13;
  localparam logic [2:0] RATE_RESET      = 3'h6;
  localparam logic [2:0] RATE_IMMEDIATE  = 3'h7;

  localparam int CLK_PERIOD_NS = 20;
  // Time to move 1 mV at each ramp code, in ns (0.11 .. 7.2 mV/us)
  localparam int STEP_NS [7] = '{9091, 4545, 2222, 1111, 556, 278, 139};

  localparam logic [11:0] MV_BASE_FINE   = 12'h2D5;
  localparam logic [11:0] MV_STEP_FINE   = 12'h019;
  localparam logic [11:0] MV_BASE_MID    = 12'h60E;
  localparam logic [11:0] MV_STEP_MID    = 12'h032;
  localparam logic [11:0] MV_BASE_COARSE = 12'hBB8;
  localparam logic [11:0] MV_STEP_COARSE = 12'h064;
  localparam logic [5:0]  CODE_MID_FIRST    = 6'h20;
  localparam logic [5:0]  CODE_COARSE_FIRST = 6'h3C;

  function automatic logic [11:0] code_to_mv(input logic [5:0] code);
    logic [11:0] c;
    c = {6'h00, code};
    if (code < CODE_MID_FIRST)
      code_to_mv = MV_BASE_FINE + MV_STEP_FINE * c;
    else if (code < CODE_COARSE_FIRST)
      code_to_mv = MV_BASE_MID + MV_STEP_MID * (c - {6'h00, CODE_MID_FIRST});
    else
      code_to_mv = MV_BASE_COARSE + MV_STEP_COARSE * (c - {6'h00, CODE_COARSE_FIRST});
  endfunction : code_to_mv

  function automatic logic [8:0] step_cycles(input logic [2:0] rate);
    int i;
    i = 0;
    step_cycles = 9'h001;
    for (i = 0; i < 7; i++)
      if (rate == 3'(i))
        step_cycles = 9'(STEP_NS[i] / CLK_PERIOD_NS);
  endfunction : step_cycles

endpackage : buck_voltage_select_pkg

// File: hdl/buck_voltage_select_regs.sv
/*
  Register bank for the third step-down converter: low and high voltage
  codes, external-adjust flag and output ramp rate, plus the ramp engine
  that moves the ramp output toward the latched target.
  Assumes the serial interface engine presents byte accesses on i_clk, and
  that the level pin and lockout flag arrive asynchronously.
*/
`timescale 1ns/1ps

module buck_voltage_select_regs
  import buck_voltage_select_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_undervoltage_lockout,
  input  wire logic        i_nv_ext_adjust,
  input  wire logic        i_buck3_level_select_pin,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [7:0]  i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic      [7:0]  o_reg_rdata,
  output logic             o_reg_rvalid,
  output logic             o_buck3_external_adjust,
  output logic      [11:0] o_target_mv,
  output logic      [11:0] o_ramp_mv,
  output logic             o_ramping
);

  logic        undervoltage_lockout_s1;
  logic        undervoltage_lockout_s2;
  logic        pin_s1;
  logic        pin_s2;
  logic        pin_s3;
  logic [5:0]  buck3_low_level_voltage;
  logic [5:0]  buck3_high_level_voltage;
  logic        buck3_external_adjust;
  logic [2:0]  ramp_rate_field;
  logic [8:0]  step_cnt;
  logic        reload;
  logic        pin_edge;
  logic        level_write;
  logic [5:0]  selected_code;
  logic [5:0]  written_code;
  logic [11:0] next_ramp_mv;

  // Two stages before any logic sees the asynchronous inputs
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      undervoltage_lockout_s1 <= 1'b0;
      undervoltage_lockout_s2 <= 1'b0;
      pin_s1  <= 1'b0;
      pin_s2  <= 1'b0;
      pin_s3  <= 1'b0;
    end
    else
    begin
      undervoltage_lockout_s1 <= i_undervoltage_lockout;
      undervoltage_lockout_s2 <= undervoltage_lockout_s1;
      pin_s1  <= i_buck3_level_select_pin;
      pin_s2  <= pin_s1;
      pin_s3  <= pin_s2;
    end
  end

  assign reload      = i_rst || undervoltage_lockout_s2;
  assign pin_edge    = pin_s2 ^ pin_s3;
  assign level_write = i_reg_wr && !undervoltage_lockout_s2
                       && (i_reg_addr == LOW_LEVEL_OFFSET || i_reg_addr == HIGH_LEVEL_OFFSET);

  always_comb
  begin
    if (pin_s2)
      selected_code = buck3_high_level_voltage;
    else
      selected_code = buck3_low_level_voltage;
  end

  // write to the selected level register retargets at once
  // The register only lands on this edge, so the new code is taken from the bus
  always_comb
  begin
    written_code = selected_code;
    if (level_write && pin_s2 && i_reg_addr == HIGH_LEVEL_OFFSET)
      written_code = i_reg_wdata[CODE_MSB:0];
    else if (level_write && !pin_s2 && i_reg_addr == LOW_LEVEL_OFFSET)
      written_code = i_reg_wdata[CODE_MSB:0];
  end

  always_ff @(posedge i_clk)
  begin
    if (reload)
      buck3_low_level_voltage <= LOW_CODE_RESET;
    else if (i_reg_wr && i_reg_addr == LOW_LEVEL_OFFSET)
      buck3_low_level_voltage <= i_reg_wdata[CODE_MSB:0];
  end

  // external-adjust cleared by reset, reloaded from the nonvolatile bit on lockout
  always_ff @(posedge i_clk)
  begin
    if (reload)
    begin
      buck3_high_level_voltage <= HIGH_CODE_RESET;
      buck3_external_adjust    <= i_rst ? 1'b0 : i_nv_ext_adjust;
    end
    else if (i_reg_wr && i_reg_addr == HIGH_LEVEL_OFFSET)
    begin
      buck3_high_level_voltage <= i_reg_wdata[CODE_MSB:0];
      buck3_external_adjust    <= i_reg_wdata[EXT_ADJUST_BIT];
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (reload)
      ramp_rate_field <= RATE_RESET;
    else if (i_reg_wr && i_reg_addr == RAMP_RATE_OFFSET)
      ramp_rate_field <= i_reg_wdata[RATE_MSB:0];
  end

  assign o_buck3_external_adjust = buck3_external_adjust;

  // Read data registered; unmapped offsets return zero
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_reg_rdata  <= 8'h00;
      o_reg_rvalid <= 1'b0;
    end
    else
    begin
      o_reg_rvalid <= i_reg_rd;
      if (!i_reg_rd)
        o_reg_rdata <= o_reg_rdata;
      else if (i_reg_addr == LOW_LEVEL_OFFSET)
        o_reg_rdata <= {2'b00, buck3_low_level_voltage};
      else if (i_reg_addr == HIGH_LEVEL_OFFSET)
        o_reg_rdata <= {buck3_external_adjust, 1'b0, buck3_high_level_voltage};
      else if (i_reg_addr == RAMP_RATE_OFFSET)
        o_reg_rdata <= {5'h00, ramp_rate_field};
      else
        o_reg_rdata <= 8'h00;
    end
  end

  // target latched on pin edge or level write
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_target_mv <= code_to_mv(LOW_CODE_RESET);
    else if (undervoltage_lockout_s2)
      o_target_mv <= code_to_mv(pin_s2 ? HIGH_CODE_RESET : LOW_CODE_RESET);
    else if (pin_edge || level_write)
      o_target_mv <= code_to_mv(written_code);
  end

  always_comb
  begin
    if (o_ramp_mv < o_target_mv)
      next_ramp_mv = o_ramp_mv + 12'h001;
    else if (o_ramp_mv > o_target_mv)
      next_ramp_mv = o_ramp_mv - 12'h001;
    else
      next_ramp_mv = o_ramp_mv;
  end

  // one millivolt per step period; code 7 jumps
  // ramp frozen while the external divider sets the output
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_ramp_mv <= code_to_mv(LOW_CODE_RESET);
      step_cnt  <= 9'h000;
    end
    else if (buck3_external_adjust)
      step_cnt <= 9'h000;
    else if (ramp_rate_field == RATE_IMMEDIATE)
    begin
      o_ramp_mv <= o_target_mv;
      step_cnt  <= 9'h000;
    end
    else if (o_ramp_mv == o_target_mv)
      step_cnt <= 9'h000;
    else if (step_cnt >= step_cycles(ramp_rate_field) - 9'h001)
    begin
      o_ramp_mv <= next_ramp_mv;
      step_cnt  <= 9'h000;
    end
    else
      step_cnt <= step_cnt + 9'h001;
  end

  assign o_ramping = !buck3_external_adjust && (o_ramp_mv != o_target_mv);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  level_select_a : assert property (pin_edge && !undervoltage_lockout_s2 && !level_write |=>
    o_target_mv == code_to_mv($past(pin_s2) ? $past(buck3_high_level_voltage)
                                            : $past(buck3_low_level_voltage)))
    else $error("target does not follow level pin");

  ext_adjust_a : assert property (undervoltage_lockout_s2 |=>
    buck3_external_adjust == $past(i_nv_ext_adjust))
    else $error("external adjust not loaded from nonvolatile bit");

  high_read_a : assert property (i_reg_rd && i_reg_addr == HIGH_LEVEL_OFFSET |=>
    o_reg_rvalid && o_reg_rdata[6] == 1'b0
    && o_reg_rdata[5:0] == $past(buck3_high_level_voltage))
    else $error("high register read wrong");

  lockout_reload_a : assert property (undervoltage_lockout_s2 |=>
    ramp_rate_field == RATE_RESET && buck3_high_level_voltage == HIGH_CODE_RESET
    && buck3_low_level_voltage == LOW_CODE_RESET)
    else $error("lockout did not reload defaults");

  decode_range_a : assert property (o_target_mv >= MV_BASE_FINE
    && o_target_mv <= code_to_mv(6'h3F))
    else $error("decoded target out of range");

  rate_read_a : assert property (i_reg_rd && i_reg_addr == RAMP_RATE_OFFSET |=>
    o_reg_rdata == {5'h00, $past(ramp_rate_field)})
    else $error("ramp register read wrong");

  slope_a : assert property (ramp_rate_field != RATE_IMMEDIATE
    && $past(ramp_rate_field) != RATE_IMMEDIATE && o_ramp_mv != $past(o_ramp_mv) |=>
    o_ramp_mv == $past(o_ramp_mv) || $past(ramp_rate_field) != ramp_rate_field
    || buck3_external_adjust)
    else $error("ramp stepped twice within a step period");

  immediate_a : assert property (ramp_rate_field == RATE_IMMEDIATE
    && !buck3_external_adjust |=> o_ramp_mv == $past(o_target_mv))
    else $error("immediate rate did not jump");

  write_start_a : assert property (level_write && !pin_edge |=>
    o_target_mv == code_to_mv(pin_s3 ? buck3_high_level_voltage
                                     : buck3_low_level_voltage))
    else $error("write did not start a ramp");

  ext_hold_a : assert property (buck3_external_adjust && $past(buck3_external_adjust) |->
    o_ramp_mv == $past(o_ramp_mv) && !o_ramping)
    else $error("ramp moved under external adjust");

endmodule : buck_voltage_select_regs

// File: test/reg_host_model.sv
/*
  Host-side model that drives the byte register port behind the serial engine.
  Assumes the bench calls its task; signals change only on the falling edge.
*/
`timescale 1ns/1ps
module reg_host_model
(
  input  wire logic       i_clk,
  output logic      [7:0] o_addr,
  output logic      [7:0] o_wdata,
  output logic            o_wr,
  output logic            o_rd
);
  initial
  begin
    o_addr  = 8'h00;
    o_wdata = 8'h00;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
  end

  // Strobe covers one rising edge; the address is inverted once idle and write data is inverted on reads, so stale values never match
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data);
    @(negedge i_clk);
    o_addr  <= addr;
    o_wdata <= wr ? data : ~o_wdata;
    o_wr    <= wr;
    o_rd    <= ~wr;
    @(negedge i_clk);
    o_wr    <= 1'b0;
    o_rd    <= 1'b0;
    o_addr  <= ~addr;
  endtask : access
endmodule : reg_host_model

// File: test/tb.sv
/*
  Self-checking bench for the converter voltage-select register bank.
  Assumes 50 MHz clock and the one-cycle read answer of the register port.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module tb;
  import buck_voltage_select_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        undervoltage_lockout  = 1'b0;
  logic        nv    = 1'b0;
  logic        pin   = 1'b0;
  logic [7:0]  addr, wdata, rdata;
  logic        wr, rd, rvalid, ext, ramping;
  logic [11:0] target_mv, ramp_mv;
  logic [7:0]  exp_q[$];
  logic [7:0]  exp_rd;
  logic [31:0] lfsr = 32'h00014A83;
  int          miscompares = 0;
  int          n_tests = 0;
  int          cycles = 0;
  logic [5:0]  codes [6] = '{6'h00, 6'h1F, 6'h20, 6'h3B, 6'h3C, 6'h3F};
  logic [11:0] mvs   [6] = '{12'h2D5, 12'h5DC, 12'h60E, 12'hB54, 12'hBB8, 12'hCE4};

  always #10 i_clk = ~i_clk;

  buck_voltage_select_regs buck_voltage_select_regs_i (.i_clk(i_clk), .i_rst(i_rst),
    .i_undervoltage_lockout(undervoltage_lockout), .i_nv_ext_adjust(nv), .i_buck3_level_select_pin(pin),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
    .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .o_buck3_external_adjust(ext),
    .o_target_mv(target_mv), .o_ramp_mv(ramp_mv), .o_ramping(ramping));
  reg_host_model reg_host_model_i (.i_clk(i_clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr),
    .o_rd(rd));

  task automatic final_report;
    if (miscompares == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    reg_host_model_i.access(1'b1, a, d);
  endtask : wreg

  // Expected read data is queued before the read is issued
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    reg_host_model_i.access(1'b0, a, 8'h00);
  endtask : rreg

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask : wait_cyc

  // Pop once per answer; an answer with no note compares against unknown and fails
  always @(negedge i_clk)
    if (rvalid === 1'b1)
    begin
      exp_rd = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
      `CHK(rdata, exp_rd)
    end

  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      miscompares++;
      final_report();
    end
  end

  initial
  begin
    wait_cyc(3);
    i_rst <= 1'b0;
    rreg(8'h13, 8'h0B);
    rreg(8'h14, 8'h13);
    rreg(8'h15, 8'h06);
    rreg(8'h20, 8'h00);
    wreg(8'h13, 8'h3F);
    wait_cyc(2);
    `CHK(ramping, 1'b1)
    wreg(8'h15, 8'hFF);
    rreg(8'h15, 8'h07);
    wait_cyc(3);
    `CHK(ramp_mv, 12'hCE4)
    for (int i = 0; i < 6; i++)
    begin
      wreg(8'h13, {2'b11, codes[i]});
      wait_cyc(3);
      `CHK(target_mv, mvs[i])
      `CHK(ramp_mv, mvs[i])
    end
    wreg(8'h14, 8'h3C);
    pin <= 1'b1;
    wait_cyc(6);
    `CHK(target_mv, 12'hBB8)
    pin <= 1'b0;
    wait_cyc(6);
    `CHK(target_mv, 12'hCE4)
    wreg(8'h14, 8'hFF);
    rreg(8'h14, 8'hBF);
    `CHK(ext, 1'b1)
    `CHK(ramping, 1'b0)
    for (int i = 0; i < 8; i++)
    begin
      lfsr = lfsr_next(lfsr);
      wreg(8'h13, lfsr[7:0]);
      rreg(8'h13, {2'b00, lfsr[5:0]});
      wreg(8'h15, lfsr[15:8]);
      rreg(8'h15, {5'b00000, lfsr[10:8]});
    end
    nv   <= 1'b1;
    undervoltage_lockout <= 1'b1;
    wait_cyc(5);
    undervoltage_lockout <= 1'b0;
    wait_cyc(4);
    rreg(8'h13, 8'h0B);
    rreg(8'h14, 8'h93);
    rreg(8'h15, 8'h06);
    `CHK(target_mv, 12'h3E8)
    wait_cyc(3);
    `CHK(exp_q.size(), 0)
    final_report();
  end
endmodule : tb
